/* File: src/fios_pkg.sv */
package fios_pkg;
   // Bus and register map
   localparam logic [31:0] REG_CONFIG  = 32'h0000_0000;
   localparam logic [31:0] REG_STATUS  = 32'h0000_0004;
   localparam logic [31:0] REG_IMAGE0  = 32'h0000_0008;
   localparam logic [31:0] REG_IMAGE1  = 32'h0000_000c;
   localparam logic [31:0] REG_OUTPUT  = 32'h0000_0010;
   localparam logic [31:0] REG_IRQ_ST  = 32'h0000_0014;
   localparam logic [31:0] REG_IRQ_MSK = 32'h0000_0018;
   localparam logic [31:0] REG_LEDS    = 32'h0000_001c;
   localparam logic [7:0]  ADDR_MASK   = 8'hfc;

   // Configuration fields
   localparam int CFG_RATE_LSB   = 0;
   localparam int CFG_AUTO_BIT   = 2;
   localparam int CFG_UNCONN_BIT = 3;
   localparam int CFG_FAST_BIT   = 4;
   localparam int CFG_DSUP_BIT   = 5;
   localparam logic [31:0] CFG_RESET = 32'h0000_0004;
   localparam logic [31:0] CFG_WMASK = 32'h0000_003f;

   // Status fields
   localparam int ST_RATE_LSB = 0;
   localparam int ST_AUTO_BIT = 2;
   localparam int ST_ADDR_LSB = 8;
   localparam int ST_LINK_LSB = 16;

   // Image field positions
   localparam int IMG_AUX_BIT = 6;
   localparam int PTS         = 8;

   // Interrupt events
   localparam int IRQ_SHORT = 0;
   localparam int IRQ_OPEN  = 1;
   localparam int IRQ_AUX   = 2;
   localparam int IRQ_LINK  = 3;
   localparam int IRQ_N     = 4;

   // Flash timing: half period 500 ms
   localparam longint FLASH_HALF_NS = 500000000;
   localparam longint CLK_NS        = 10;
   localparam int FLASH_HALF_CYC = int'(FLASH_HALF_NS / CLK_NS);

   // Bit rate codes
   typedef enum logic [1:0] {
      FIOS_RATE_125 = 2'h0,
      FIOS_RATE_250 = 2'h1,
      FIOS_RATE_500 = 2'h2,
      FIOS_RATE_RSV = 2'h3
   } fios_rate_t;
   localparam logic [3:0] SW_RATE_AUTO = 4'h9;

   // Network link states from the protocol engine
   typedef enum logic [1:0] {
      FIOS_NET_WAIT    = 2'h0,
      FIOS_NET_OK      = 2'h1,
      FIOS_NET_TIMEOUT = 2'h2,
      FIOS_NET_FAIL    = 2'h3
   } fios_net_t;

   // Two-bit LED colour codes
   localparam logic [1:0] LED_OFF   = 2'h0;
   localparam logic [1:0] LED_GREEN = 2'h1;
   localparam logic [1:0] LED_RED   = 2'h2;
   localparam logic [1:0] LED_AMBER = 2'h3;
endpackage : fios_pkg

/* File: src/fios_flash.sv */
`timescale 1ns/1ns
`default_nettype none
module fios_flash
   import fios_pkg::*;
(
   input  wire logic clk,      // System clock
   input  wire logic reset_n,  // Sync reset
   output logic      phase     // Flash phase
);
   logic [31:0] count;
   logic [31:0] next_count;
   logic        next_phase;

   always_comb begin
      next_count = count + 32'h1;
      next_phase = phase;
      if (count == 32'(FLASH_HALF_CYC - 1)) begin
         next_count = 32'h0;
         next_phase = ~phase;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         count <= 32'h0;
         phase <= 1'b0;
      end else begin
         count <= next_count;
         phase <= next_phase;
      end
   end
endmodule : fios_flash
`default_nettype wire

/* File: src/fios_addr.sv */
`timescale 1ns/1ns
`default_nettype none
module fios_addr
   import fios_pkg::*;
(
   input  wire logic [3:0] sw_tens,   // Left switch
   input  wire logic [3:0] sw_units,  // Right switch
   output logic      [6:0] node_addr  // Decimal address
);
   // Digits above 9 are clamped to 9
   function automatic logic [6:0] digit(input logic [3:0] d);
      digit = (d > 4'h9) ? 7'h9 : {3'h0, d};
   endfunction : digit

   always_comb begin
      node_addr = 7'((digit(sw_tens) * 7'd10) + digit(sw_units));
   end
endmodule : fios_addr
`default_nettype wire

/* File: src/fios_station.sv */
`timescale 1ns/1ns
`default_nettype none
module fios_station
   import fios_pkg::*;
(
   input  wire logic        clk,                   // 100 MHz clock
   input  wire logic        reset_n,               // Sync reset
   input  wire logic        hsel,                  // AHB select
   input  wire logic [31:0] haddr,                 // AHB address
   input  wire logic [1:0]  htrans,                // AHB transfer
   input  wire logic        hwrite,                // AHB write
   input  wire logic [2:0]  hsize,                 // AHB size
   input  wire logic [31:0] hwdata,                // AHB write data
   input  wire logic        hready,                // AHB ready in
   output logic      [31:0] hrdata,                // AHB read data
   output logic             hreadyout,             // AHB ready out
   output logic             hresp,                 // AHB response
   input  wire logic        extended_diag_variant, // Extended variant strap
   input  wire logic [3:0]  sw_tens,               // Left rotary switch
   input  wire logic [3:0]  sw_units,              // Right rotary switch
   input  wire logic [3:0]  sw_rate,               // Rate rotary switch
   input  wire logic        rate_detect_busy,      // Engine detecting rate
   input  wire logic [1:0]  net_state,             // Engine link state
   input  wire logic [7:0]  input_state,           // Input points
   input  wire logic [7:0]  input_short_flag,      // Per-input short
   input  wire logic [7:0]  input_open_flag,       // Per-input open
   input  wire logic [7:0]  output_state_flag,     // Output status
   input  wire logic        aux_power_flag,        // Aux power status
   input  wire logic [7:0]  out_image,             // Output byte from master
   input  wire logic        out_image_valid,       // Output byte strobe
   output logic      [6:0]  node_addr,             // Node address
   output logic             auto_rate,             // Auto detection on
   output logic      [1:0]  bit_rate,              // Fixed rate code
   output logic             unconnected_msg_mode,  // Unconnected mode
   output logic             fast_startup,          // Fast startup on
   output logic      [39:0] in_image,              // Input image bytes 0..4
   output logic      [7:0]  out_points,            // Output commands
   output logic      [1:0]  led_module,            // Module LED colour
   output logic      [1:0]  led_network,           // Network LED colour
   output logic      [15:0] led_points,            // Point LED colours
   output logic             irq                    // Interrupt level
);
   logic             phase;
   logic [6:0]       addr_dec;
   logic [31:0]      cfg;
   logic [31:0]      next_cfg;
   logic [IRQ_N-1:0] irq_st;
   logic [IRQ_N-1:0] next_irq_st;
   logic [IRQ_N-1:0] irq_msk;
   logic [IRQ_N-1:0] next_irq_msk;
   logic             next_irq;
   logic             ap_valid;
   logic             next_ap_valid;
   logic             ap_write;
   logic             next_ap_write;
   logic [7:0]       ap_addr;
   logic [7:0]       next_ap_addr;
   logic [31:0]      next_hrdata;
   logic             any_short;
   logic             any_open;
   logic             prev_short;
   logic             prev_open;
   logic             prev_aux;
   logic [1:0]       prev_net;
   logic [IRQ_N-1:0] events;
   logic             next_auto;
   logic [1:0]       next_rate;
   logic [39:0]      next_image;
   logic [7:0]       next_outp;
   logic [1:0]       next_led_mod;
   logic [1:0]       next_led_net;
   logic [15:0]      next_led_pts;
   logic             diag_on;

   fios_flash u_flash (
      .clk     (clk),
      .reset_n (reset_n),
      .phase   (phase)
   );

   fios_addr u_addr (
      .sw_tens   (sw_tens),
      .sw_units  (sw_units),
      .node_addr (addr_dec)
   );

   function automatic logic [1:0] flash(input logic [1:0] c, input logic p);
      flash = p ? c : LED_OFF;
   endfunction : flash

   // Effective bit-rate selection
   always_comb begin
      next_auto = cfg[CFG_AUTO_BIT];
      next_rate = cfg[CFG_RATE_LSB +: 2];
      if (next_rate == FIOS_RATE_RSV) begin
         next_rate = FIOS_RATE_125;
      end
      if (extended_diag_variant) begin
         if (sw_rate == SW_RATE_AUTO) begin
            next_auto = 1'b1;
         end else if (sw_rate < 4'h3) begin
            next_auto = 1'b0;
            next_rate = sw_rate[1:0];
         end
      end else begin
         next_auto = 1'b1;
      end
   end

   // Cyclic image and output points
   always_comb begin
      any_short = |input_short_flag;
      any_open  = |input_open_flag;
      diag_on   = extended_diag_variant && !cfg[CFG_DSUP_BIT];
      next_image = 40'h0;
      next_image[7:0] = input_state;
      if (diag_on) begin
         next_image[15:8]  = input_short_flag;
         next_image[23:16] = input_open_flag;
      end else if (!extended_diag_variant) begin
         next_image[8] = any_short;
      end
      next_image[31:24] = output_state_flag;
      next_image[32 + IMG_AUX_BIT] = aux_power_flag;
      next_outp = out_image_valid ? out_image : out_points;
   end

   // Status indicators
   always_comb begin
      if (any_short) begin
         next_led_mod = flash(LED_RED, phase);
      end else if (next_auto && rate_detect_busy) begin
         next_led_mod = flash(LED_GREEN, phase);
      end else begin
         next_led_mod = LED_GREEN;
      end
      case (fios_net_t'(net_state))
         FIOS_NET_OK:      next_led_net = LED_GREEN;
         FIOS_NET_WAIT:    next_led_net = flash(LED_GREEN, phase);
         FIOS_NET_TIMEOUT: next_led_net = flash(LED_RED, phase);
         FIOS_NET_FAIL:    next_led_net = LED_RED;
         default:          next_led_net = LED_OFF;
      endcase
      for (int i = 0; i < PTS; i++) begin
         if (extended_diag_variant && input_short_flag[i]) begin
            next_led_pts[2*i +: 2] = LED_RED;
         end else if (extended_diag_variant && input_open_flag[i]) begin
            next_led_pts[2*i +: 2] = LED_AMBER;
         end else begin
            next_led_pts[2*i +: 2] = input_state[i] ? LED_GREEN : LED_OFF;
         end
      end
   end

   // Change events for the interrupt status
   always_comb begin
      events = '0;
      events[IRQ_SHORT] = any_short && !prev_short;
      events[IRQ_OPEN]  = any_open && !prev_open;
      events[IRQ_AUX]   = aux_power_flag != prev_aux;
      events[IRQ_LINK]  = net_state != prev_net;
   end

   // AHB-Lite slave, zero wait states
   always_comb begin
      next_ap_valid = hsel && hready && htrans[1];
      next_ap_write = hwrite;
      next_ap_addr  = haddr[7:0] & ADDR_MASK;
      next_cfg      = cfg;
      next_irq_msk  = irq_msk;
      next_irq_st   = irq_st;
      next_hrdata   = 32'h0;
      // Data phase: write data stands on hwdata now
      if (ap_valid && ap_write) begin
         case ({24'h0, ap_addr})
            REG_CONFIG:  next_cfg = hwdata & CFG_WMASK;
            REG_IRQ_MSK: next_irq_msk = hwdata[IRQ_N-1:0];
            default:     next_cfg = cfg;
         endcase
      end
      // Address phase: read data registered for the data phase
      if (next_ap_valid && !hwrite) begin
         case ({24'h0, next_ap_addr})
            REG_CONFIG:  next_hrdata = cfg;
            REG_STATUS: begin
               next_hrdata[ST_RATE_LSB +: 2] = bit_rate;
               next_hrdata[ST_AUTO_BIT]      = auto_rate;
               next_hrdata[ST_ADDR_LSB +: 7] = node_addr;
               next_hrdata[ST_LINK_LSB +: 2] = net_state;
            end
            REG_IMAGE0:  next_hrdata = in_image[31:0];
            REG_IMAGE1:  next_hrdata = {24'h0, in_image[39:32]};
            REG_OUTPUT:  next_hrdata = {24'h0, out_points};
            REG_IRQ_ST: begin
               next_hrdata = {28'h0, irq_st};
               next_irq_st = '0;
            end
            REG_IRQ_MSK: next_hrdata = {28'h0, irq_msk};
            REG_LEDS: next_hrdata = {12'h0, led_points, led_network, led_module};
            default:     next_hrdata = 32'h0;
         endcase
      end
      next_irq_st = next_irq_st | events;  // Set wins over clear
      next_irq = |(next_irq_st & next_irq_msk);
   end

   // Bus interface registers
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         ap_valid <= 1'b0;
         ap_write <= 1'b0;
         ap_addr <= 8'h0;
         hrdata <= 32'h0;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         ap_valid <= next_ap_valid;
         ap_write <= next_ap_write;
         ap_addr <= next_ap_addr;
         hrdata <= next_hrdata;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   // Configuration and interrupt registers
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         cfg <= CFG_RESET;
         irq_st <= '0;
         irq_msk <= '0;
         irq <= 1'b0;
      end else begin
         cfg <= next_cfg;
         irq_st <= next_irq_st;
         irq_msk <= next_irq_msk;
         irq <= next_irq;
      end
   end

   // History for the event edge detectors, idle levels after reset
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         prev_short <= 1'b0;
         prev_open <= 1'b0;
         prev_aux <= 1'b0;
         prev_net <= 2'h0;
      end else begin
         prev_short <= any_short;
         prev_open <= any_open;
         prev_aux <= aux_power_flag;
         prev_net <= net_state;
      end
   end

   // Registered station outputs
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         node_addr <= 7'h0;
         auto_rate <= 1'b1;
         bit_rate <= FIOS_RATE_125;
         unconnected_msg_mode <= 1'b0;
         fast_startup <= 1'b0;
         in_image <= 40'h0;
         out_points <= 8'h0;
         led_module <= LED_OFF;
         led_network <= LED_OFF;
         led_points <= 16'h0;
      end else begin
         node_addr <= addr_dec;
         auto_rate <= next_auto;
         bit_rate <= next_rate;
         unconnected_msg_mode <= cfg[CFG_UNCONN_BIT];
         fast_startup <= cfg[CFG_FAST_BIT];
         in_image <= next_image;
         out_points <= next_outp;
         led_module <= next_led_mod;
         led_network <= next_led_net;
         led_points <= next_led_pts;
      end
   end
endmodule : fios_station
`default_nettype wire

/* File: bench/fios_checker_assertions.sv */
`timescale 1ns/1ns
`default_nettype none
module fios_checker
   import fios_pkg::*;
(
   input wire logic        clk, // Clock
   input wire logic        reset_n, // Reset
   input wire logic        extended_diag_variant, // Variant
   input wire logic [3:0]  sw_tens, // Tens
   input wire logic [3:0]  sw_units, // Units
   input wire logic [7:0]  input_state, // Inputs
   input wire logic [7:0]  input_short_flag, // Shorts
   input wire logic [7:0]  output_state_flag, // Out status
   input wire logic        aux_power_flag, // Aux
   input wire logic [7:0]  out_image, // Master byte
   input wire logic        out_image_valid, // Strobe
   input wire logic [1:0]  net_state, // Link
   input wire logic [6:0]  node_addr, // Address
   input wire logic        auto_rate, // Auto rate
   input wire logic [39:0] in_image, // Image
   input wire logic [7:0]  out_points, // Outputs
   input wire logic [1:0]  led_network // Net LED
);
   logic [1:0] rs;
   logic       live;
   // Outputs track inputs from the first edge after release; checks start at the third
   always_ff @(posedge clk) rs <= {rs[0], reset_n};
   assign live = rs[1];
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   property p_addr;
      live && $past(sw_tens) < 4'ha && $past(sw_units) < 4'ha |->
         node_addr == $past(sw_tens) * 7'd10 + $past(sw_units);
   endproperty
   a_addr: assert property (p_addr) else $error("bad address");
   property p_auto;
      live && !$past(extended_diag_variant) |-> auto_rate;
   endproperty
   a_auto: assert property (p_auto) else $error("auto off");
   property p_img;
      live |-> in_image[7:0] == $past(input_state) &&
         in_image[31:24] == $past(output_state_flag);
   endproperty
   a_img: assert property (p_img) else $error("bad image");
   property p_aux;
      live |-> in_image[39:32] == {1'b0, $past(aux_power_flag), 6'h0};
   endproperty
   a_aux: assert property (p_aux) else $error("bad byte 4");
   property p_diag;
      live && !$past(extended_diag_variant) |->
         in_image[23:8] == {15'h0, |$past(input_short_flag)};
   endproperty
   a_diag: assert property (p_diag) else $error("bad group bit");
   property p_out;
      live && out_image_valid |=> out_points == $past(out_image);
   endproperty
   a_out: assert property (p_out) else $error("bad outputs");
   property p_net_ok;
      live && $past(net_state) == FIOS_NET_OK |-> led_network == LED_GREEN;
   endproperty
   a_net_ok: assert property (p_net_ok) else $error("net not green");
   property p_net_fail;
      (live && net_state == FIOS_NET_FAIL) [*2] |-> led_network == LED_RED;
   endproperty
   a_net_fail: assert property (p_net_fail) else $error("net not red");
   c_out: cover property (live && out_image_valid);
   c_fail: cover property (live && net_state == FIOS_NET_FAIL);
   c_grp: cover property (live && !extended_diag_variant && |input_short_flag);
endmodule : fios_checker
bind fios_station fios_checker u_chk (.clk(clk), .reset_n(reset_n),
   .extended_diag_variant(extended_diag_variant), .sw_tens(sw_tens),
   .sw_units(sw_units), .input_state(input_state),
   .input_short_flag(input_short_flag),
   .output_state_flag(output_state_flag), .aux_power_flag(aux_power_flag),
   .out_image(out_image), .out_image_valid(out_image_valid),
   .net_state(net_state), .node_addr(node_addr), .auto_rate(auto_rate),
   .in_image(in_image), .out_points(out_points),
   .led_network(led_network));
`default_nettype wire

/* File: bench/fios_master_model.sv */
`timescale 1ns/1ns
`default_nettype none
module fios_master_model
   import fios_pkg::*;
(
   input  wire logic       clk, // Clock
   output logic      [7:0] out_image, // Output byte
   output logic            out_image_valid, // Byte strobe
   output logic      [1:0] net_state // Link state
);
   initial begin
      out_image = 8'h00;
      out_image_valid = 1'b0;
      net_state = FIOS_NET_WAIT;
   end
   // Bit n of the byte commands output point n
   task automatic send(input logic [7:0] b);
      @(posedge clk);
      out_image <= b;
      out_image_valid <= 1'b1;
      @(posedge clk);
      out_image_valid <= 1'b0;
      out_image <= ~b;
   endtask : send
   task automatic link(input fios_net_t s);
      @(posedge clk);
      net_state <= s;
   endtask : link
endmodule : fios_master_model
`default_nettype wire

/* File: bench/fieldbus_io_station_status_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin num_errors++; \
   $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module fieldbus_io_station_status_tb_top;
   import fios_pkg::*;
   logic        clk = 1'b0;
   logic        reset_n, hsel, hwrite, ext, busy, aux, ovld, hrdy;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0]  htrans, nst, brate, ledm, ledn;
   logic [2:0]  hsize;
   logic [3:0]  sw_t, sw_u, sw_r;
   logic [7:0]  ins, shr, opn, ost, oimg, opts;
   logic [6:0]  naddr;
   logic [39:0] img;
   logic [15:0] ledp;
   logic        arate, uncon, fast, irq, hrsp;
   int          num_errors = 0;
   int          checked = 0;
   logic [1:0]  exp_n [4] = '{LED_OFF, LED_GREEN, LED_OFF, LED_RED};
   always #5 clk = ~clk;
   fios_station dut (.clk(clk), .reset_n(reset_n), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hrdy), .hrdata(hrdata), .hreadyout(hrdy),
      .hresp(hrsp), .extended_diag_variant(ext), .sw_tens(sw_t),
      .sw_units(sw_u), .sw_rate(sw_r), .rate_detect_busy(busy),
      .net_state(nst), .input_state(ins), .input_short_flag(shr),
      .input_open_flag(opn), .output_state_flag(ost),
      .aux_power_flag(aux), .out_image(oimg), .out_image_valid(ovld),
      .node_addr(naddr), .auto_rate(arate), .bit_rate(brate),
      .unconnected_msg_mode(uncon), .fast_startup(fast), .in_image(img),
      .out_points(opts), .led_module(ledm), .led_network(ledn),
      .led_points(ledp), .irq(irq));
   fios_master_model m (.clk(clk), .out_image(oimg),
      .out_image_valid(ovld), .net_state(nst));
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
   endtask : wt
   // One AHB single transfer; read data lands in rd
   task automatic bus(input logic w, input logic [31:0] a,
                      input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge clk); while (hrdy !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hrdy !== 1'b1);
      rd = hrdata;
   endtask : bus
   task automatic summarize();
      $display("errors %0d checks %0d", num_errors, checked);
      if (num_errors == 0 && checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : summarize
   initial begin
      repeat (20000) @(posedge clk);
      num_errors++;
      summarize();
   end
   initial begin
      {reset_n, hsel, hwrite, busy, aux, haddr, hwdata} = '0;
      {ins, shr, opn, ost, sw_t, sw_u, htrans} = '0;
      {ext, sw_r, hsize} = {1'b1, 4'h5, 3'h2};
      wt(6);
      reset_n <= 1'b1;
      wt(3);
      for (int t = 0; t < 10; t++) begin
         sw_t <= 4'(t);
         sw_u <= 4'(9 - t);
         wt(2);
         `CHK(naddr, 7'(t * 10 + 9 - t))
      end
      bus(1'b0, REG_CONFIG, 32'h0);
      `CHK({hrsp, rd}, {1'b0, CFG_RESET})
      `CHK({arate, brate}, 3'b100)
      `CHK(uncon, 1'b0)
      `CHK(fast, 1'b0)
      bus(1'b0, REG_STATUS, 32'h0);
      `CHK(rd, 32'h0000_5a04)
      for (int r = 0; r < 3; r++) begin
         bus(1'b1, REG_CONFIG, 32'h18 | r);
         wt(2);
         `CHK({arate, brate}, {1'b0, 2'(r)})
      end
      `CHK({uncon, fast}, 2'b11)
      sw_r <= 4'h9;
      wt(2);
      `CHK(arate, 1'b1)
      sw_r <= 4'h1;
      wt(2);
      `CHK({arate, brate}, 3'b001)
      ext <= 1'b0;
      ins <= 8'h05;
      shr <= 8'h02;
      opn <= 8'h08;
      ost <= 8'hc3;
      aux <= 1'b1;
      wt(2);
      `CHK(arate, 1'b1)
      `CHK(img, 40'h40_c3_00_01_05)
      ext <= 1'b1;
      wt(2);
      `CHK(img, 40'h40_c3_08_02_05)
      `CHK(ledp[7:0], {LED_AMBER, LED_GREEN, LED_RED, LED_GREEN})
      `CHK(ledm == LED_GREEN, 1'b0)
      bus(1'b0, REG_IMAGE1, 32'h0);
      `CHK(rd, 32'h40)
      bus(1'b1, REG_CONFIG, 32'h3a);
      wt(2);
      `CHK(img[23:8], 16'h0)
      {shr, opn} <= '0;
      wt(2);
      `CHK(ledm, LED_GREEN)
      sw_r <= 4'h9;
      busy <= 1'b1;
      wt(2);
      `CHK(ledm, LED_OFF)
      busy <= 1'b0;
      for (int i = 0; i < 4; i++) begin
         m.link(fios_net_t'(i));
         wt(2);
         `CHK(ledn, exp_n[i])
      end
      bus(1'b0, REG_IRQ_ST, 32'h0);
      bus(1'b1, REG_IRQ_MSK, 32'h1);
      wt(2);
      `CHK(irq, 1'b0)
      shr <= 8'h04;
      wt(3);
      `CHK(irq, 1'b1)
      bus(1'b0, REG_IRQ_ST, 32'h0);
      `CHK(rd[IRQ_SHORT], 1'b1)
      wt(2);
      `CHK(irq, 1'b0)
      bus(1'b0, 32'h40, 32'h0);
      `CHK(rd, 32'h0)
      m.send(8'h96);
      wt(2);
      `CHK(opts, 8'h96)
      bus(1'b0, REG_OUTPUT, 32'h0);
      `CHK(rd, 32'h96)
      summarize();
   end
endmodule : fieldbus_io_station_status_tb_top
`default_nettype wire
